/* File: verilog/scs_pkg.sv */
// Package for the slow and fast RC clock select block
package scs_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          TRIM_W        = 7;
    localparam int          CLK_HZ        = 20_000_000;
    // Register offsets
    localparam logic [7:0]  SUP_CTRL_ADDR = 8'h00;
    localparam logic [7:0]  SUP_MODE_ADDR = 8'h04;
    localparam logic [7:0]  SUP_STAT_ADDR = 8'h08;
    localparam logic [7:0]  MAIN_OSC_ADDR = 8'h0c;
    localparam logic [7:0]  PWR_STAT_ADDR = 8'h10;
    localparam logic [7:0]  PWR_IEN_ADDR  = 8'h14;
    localparam logic [7:0]  OSC_TRIM_ADDR = 8'h18;
    // Field positions
    localparam int          XTAL_SEL_BIT  = 0;
    localparam int          BYPASS_BIT    = 0;
    localparam int          SRC_DONE_BIT  = 0;
    localparam int          RC_EN_BIT     = 0;
    localparam int          FREQ_LSB      = 4;
    localparam int          FREQ_W        = 3;
    localparam int          STABLE_BIT    = 0;
    localparam int          TRIM_STRIDE   = 8;
    localparam int          OVR_BIT       = 7;
    // Frequency codes
    localparam logic [2:0]  FREQ_4MHZ     = 3'h0;
    localparam logic [2:0]  FREQ_8MHZ     = 3'h1;
    localparam logic [2:0]  FREQ_12MHZ    = 3'h2;
    // Reset values
    localparam logic        RC_EN_RST     = 1'h1;
    localparam logic [2:0]  FREQ_RST      = FREQ_4MHZ;
    // Timing
    localparam int          SLOW_VALID_US = 100;
    localparam int          SLOW_VALID_CY = (SLOW_VALID_US * (CLK_HZ / 1_000_000));
    localparam int          RC_SETTLE_SLK = 4;

    typedef enum logic [4:0] {
        SEQ_RC    = 5'b00001,
        SEQ_PINS  = 5'b00010,
        SEQ_XEN   = 5'b00100,
        SEQ_RCOFF = 5'b01000,
        SEQ_DONE  = 5'b10000
    } scs_seq_e;

    typedef struct packed {
        logic              ovr;
        logic [TRIM_W-1:0] value;
    } scs_trim_s;
endpackage

/* File: verilog/scs_clock_select.sv */
// Slow clock source select and fast RC oscillator control
//
// Overview of operation
// - At supply power-up both slow oscillators powered, only RC enabled; valid after 100 us
// - After reset slow RC runs and is the slow clock source
// - Crystal select write: pins to oscillator, enable crystal, then disable RC
// - Slow source switch is glitch free; done bit set when sequence completes
// - Crystal selection is permanent; only supply loss returns to RC
// - Crystal pins come up as general-purpose inputs after reset
// - Bypass bit makes crystal oscillator take an external clock on its input
// - After reset fast RC is enabled at 4 MHz and sources main clock
// - Fast RC enable bit turns the oscillator on or off
// - Frequency select field chooses 4, 8 or 12 MHz
// - Frequency change clears stable flag, gates main clock until settled
// - Clearing fast RC enable clears stable flag at once
// - Stable flag raises interrupt when its enable bit is set
// - Factory trims fixed; software trims reset on power-up or peripheral reset
// - Override bit low drives oscillator from factory trim for that frequency
// - Override bit high drives oscillator from software trim for that frequency
// - Trim of the frequency in use is not changed by software
`timescale 1ns/100ps
module scs_clock_select
    import scs_pkg::*;
#(
    parameter int SETTLE_SLK = RC_SETTLE_SLK
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              periphRst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    input  wire logic              slowClockIn,
    input  wire logic [TRIM_W-1:0] factoryTrimLow,
    input  wire logic [TRIM_W-1:0] factoryTrimMid,
    input  wire logic [TRIM_W-1:0] factoryTrimHigh,
    output logic                   slowClockValid,
    output logic                   slowRcPower,
    output logic                   slowXtalPower,
    output logic                   slowRcEnable,
    output logic                   slowXtalEnable,
    output logic                   slowXtalPinsToOsc,
    output logic                   slowXtalBypass,
    output logic                   slowSourceXtal,
    output logic                   fastRcEnable,
    output logic      [2:0]        fastRcFreq,
    output logic      [TRIM_W-1:0] fastRcTrim,
    output logic                   mainClockOn,
    output logic                   fastRcIrq
);
    // Settle counter is eight bits wide and needs at least one tick
    if (SETTLE_SLK < 1 || SETTLE_SLK > 255) begin : g_bad_settle
        $error("SETTLE_SLK out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow clock synchroniser and tick
    logic slowSync1_reg, slowSync2_reg, slowSync3_reg;
    logic slowTick;

    always_ff @(posedge sys_clk) begin
        slowSync1_reg <= slowClockIn;
        slowSync2_reg <= slowSync1_reg;
        slowSync3_reg <= slowSync2_reg;
    end
    assign slowTick = slowSync2_reg & ~slowSync3_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wrCtrl, wrMode, wrMain, wrIen, wrTrim;
    assign wrCtrl = regWr && (regAddr == SUP_CTRL_ADDR);
    assign wrMode = regWr && (regAddr == SUP_MODE_ADDR);
    assign wrMain = regWr && (regAddr == MAIN_OSC_ADDR);
    assign wrIen  = regWr && (regAddr == PWR_IEN_ADDR);
    assign wrTrim = regWr && (regAddr == OSC_TRIM_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // Slow clock valid timer after supply power-up
    logic [11:0] validCnt_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            validCnt_reg   <= 12'h000;
            slowClockValid <= 1'b0;
            slowRcPower    <= 1'b1;
            slowXtalPower  <= 1'b1;
        end else begin
            if (validCnt_reg != 12'(SLOW_VALID_CY - 1)) begin
                validCnt_reg <= validCnt_reg + 12'h001;
            end
            slowClockValid <= (validCnt_reg == 12'(SLOW_VALID_CY - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow source switch sequence
    scs_seq_e seq_reg;
    logic     xtalReq_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            xtalReq_reg <= 1'b0;
        end else if (wrCtrl && regWdata[XTAL_SEL_BIT]) begin
            xtalReq_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_reg <= SEQ_RC;
        end else if (slowTick) begin
            case (seq_reg)
                SEQ_RC:    seq_reg <= xtalReq_reg ? SEQ_PINS : SEQ_RC;
                SEQ_PINS:  seq_reg <= SEQ_XEN;
                SEQ_XEN:   seq_reg <= SEQ_RCOFF;
                SEQ_RCOFF: seq_reg <= SEQ_DONE;
                SEQ_DONE:  seq_reg <= SEQ_DONE;
                default:   seq_reg <= SEQ_RC;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            slowXtalPinsToOsc <= 1'b0;
            slowXtalEnable    <= 1'b0;
            slowRcEnable      <= 1'b1;
            slowSourceXtal    <= 1'b0;
            slowXtalBypass    <= 1'b0;
        end else begin
            slowXtalPinsToOsc <= (seq_reg != SEQ_RC);
            slowXtalEnable    <= (seq_reg == SEQ_XEN) || (seq_reg == SEQ_RCOFF) || (seq_reg == SEQ_DONE);
            // Switch on a slow tick keeps the source change glitch free
            if (slowTick && seq_reg == SEQ_RCOFF) begin
                slowSourceXtal <= 1'b1;
            end
            slowRcEnable <= (seq_reg != SEQ_DONE);
            if (wrMode) begin
                slowXtalBypass <= regWdata[BYPASS_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fast RC enable, frequency and stabilisation
    logic [7:0] settleCnt_reg;
    logic       fastRcStable;
    logic       irqEn_reg;
    logic       newEn;
    logic [2:0] newFreq;
    logic       freqOk;
    logic       restart;

    assign newEn   = regWdata[RC_EN_BIT];
    assign newFreq = regWdata[FREQ_LSB +: FREQ_W];
    assign freqOk  = (newFreq == FREQ_4MHZ) || (newFreq == FREQ_8MHZ) || (newFreq == FREQ_12MHZ);
    assign restart = wrMain && newEn && (!fastRcEnable || (freqOk && newFreq != fastRcFreq));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fastRcEnable <= RC_EN_RST;
            fastRcFreq   <= FREQ_RST;
        end else if (wrMain) begin
            fastRcEnable <= newEn;
            if (freqOk) begin
                fastRcFreq <= newFreq;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            settleCnt_reg <= 8'(SETTLE_SLK);
            fastRcStable  <= 1'b0;
            mainClockOn   <= 1'b0;
        end else if (wrMain && !newEn) begin
            settleCnt_reg <= 8'h00;
            fastRcStable  <= 1'b0;
            mainClockOn   <= 1'b0;
        end else if (restart) begin
            settleCnt_reg <= 8'(SETTLE_SLK);
            fastRcStable  <= 1'b0;
            mainClockOn   <= 1'b0;
        end else if (fastRcEnable && !fastRcStable && slowTick) begin
            if (settleCnt_reg <= 8'h01) begin
                settleCnt_reg <= 8'h00;
                fastRcStable  <= 1'b1;
                mainClockOn   <= 1'b1;
            end else begin
                settleCnt_reg <= settleCnt_reg - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqEn_reg <= 1'b0;
            fastRcIrq <= 1'b0;
        end else begin
            if (wrIen) begin
                irqEn_reg <= regWdata[STABLE_BIT];
            end
            fastRcIrq <= fastRcStable && irqEn_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim registers, one per frequency
    scs_trim_s swTrim_reg [3];
    scs_trim_s trimSel;
    logic [TRIM_W-1:0] factorySel;
    logic [1:0] freqIdx;
    assign freqIdx = fastRcFreq[1:0];

    always_ff @(posedge sys_clk) begin
        if (sys_rst || periphRst) begin
            for (int i = 0; i < 3; i++) begin
                swTrim_reg[i] <= '0;
            end
        end else if (wrTrim) begin
            for (int i = 0; i < 3; i++) begin
                if (i != int'(freqIdx)) begin
                    swTrim_reg[i] <= regWdata[i*TRIM_STRIDE +: TRIM_W+1];
                end
            end
        end
    end

    always_comb begin
        trimSel = swTrim_reg[0];
        case (freqIdx)
            2'h1:    factorySel = factoryTrimMid;
            2'h2:    factorySel = factoryTrimHigh;
            default: factorySel = factoryTrimLow;
        endcase
        if (freqIdx == 2'h1) trimSel = swTrim_reg[1];
        if (freqIdx == 2'h2) trimSel = swTrim_reg[2];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fastRcTrim <= '0;
        end else begin
            fastRcTrim <= trimSel.ovr ? trimSel.value : factorySel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            regRdata <= '0;
            case (regAddr)
                SUP_MODE_ADDR: regRdata[BYPASS_BIT] <= slowXtalBypass;
                SUP_STAT_ADDR: regRdata[SRC_DONE_BIT] <= slowSourceXtal;
                MAIN_OSC_ADDR: begin
                    regRdata[RC_EN_BIT] <= fastRcEnable;
                    regRdata[FREQ_LSB +: FREQ_W] <= fastRcFreq;
                end
                PWR_STAT_ADDR: regRdata[STABLE_BIT] <= fastRcStable;
                PWR_IEN_ADDR:  regRdata[STABLE_BIT] <= irqEn_reg;
                OSC_TRIM_ADDR: begin
                    for (int i = 0; i < 3; i++) begin
                        regRdata[i*TRIM_STRIDE +: TRIM_W+1] <= swTrim_reg[i];
                    end
                end
                default: regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence xtalOn_s;
        slowXtalPinsToOsc && slowXtalEnable;
    endsequence

    xtal_stays_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        slowSourceXtal |=> slowSourceXtal) else $error("slow source left crystal");
    pins_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        slowXtalEnable |-> slowXtalPinsToOsc) else $error("crystal enabled before pins");
    rc_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(slowRcEnable) |-> xtalOn_s) else $error("RC off before crystal on");
    src_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(slowSourceXtal) |-> xtalOn_s and slowRcEnable) else $error("switch out of order");
    rc_disable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wrMain && !newEn) |=> !fastRcStable && !mainClockOn) else $error("stable kept after disable");
    freq_change_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wrMain && newEn && freqOk && newFreq != fastRcFreq) |=> !fastRcStable [*2])
        else $error("stable kept after frequency change");
    stable_clk_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fastRcStable == mainClockOn) else $error("main clock gate mismatch");
    settle_tick_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(fastRcStable) |-> $past(slowTick)) else $error("stable set off a slow tick");
    irq_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (fastRcStable && irqEn_reg) |=> fastRcIrq) else $error("interrupt not raised");
    trim_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst || periphRst)
        wrTrim |=> swTrim_reg[freqIdx] == $past(swTrim_reg[freqIdx])) else $error("in-use trim changed");
    slow_valid_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        slowClockValid |-> validCnt_reg == 12'(SLOW_VALID_CY - 1)) else $error("slow valid too early");
endmodule

/* File: verification/scs_slow_osc_model.sv */
// Behavioural model of the slow oscillators feeding the block
`timescale 1ns/100ps
module scs_slow_osc_model #(
    parameter int HALF_CY = 4
) (
    input  wire logic sys_clk,
    input  wire logic rcEnable,
    input  wire logic xtalEnable,
    input  wire logic bypass,
    input  wire logic extClk,
    output logic      slowClk
);
    int   cnt = 0;
    logic osc = 1'b0;
    ////////////////////////////////////////////////////////////////
    // Oscillator runs while either source is enabled, stands still otherwise
    always @(posedge sys_clk) begin
        if (rcEnable || xtalEnable) begin
            cnt = (cnt + 1) % HALF_CY;
            if (cnt == 0) begin
                osc <= ~osc;
            end
        end
    end
    // Bypassed crystal passes the external clock through
    assign slowClk = (xtalEnable && bypass) ? extClk : osc;
endmodule

/* File: verification/slow_and_fast_rc_clock_select_tb.sv */
// Self-checking testbench of the slow and fast RC clock select block
`timescale 1ns/100ps
module slow_and_fast_rc_clock_select_tb;
    import scs_pkg::*;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              periphRst = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic              slowClockIn;
    logic              extClk = 1'b0;
    logic [TRIM_W-1:0] fLow = 7'h11;
    logic [TRIM_W-1:0] fMid = 7'h22;
    logic [TRIM_W-1:0] fHigh = 7'h33;
    logic              slowClockValid, slowRcPower, slowXtalPower, slowRcEnable, slowXtalEnable;
    logic              slowXtalPinsToOsc, slowXtalBypass, slowSourceXtal, fastRcEnable;
    logic [2:0]        fastRcFreq;
    logic [TRIM_W-1:0] fastRcTrim;
    logic              mainClockOn, fastRcIrq;
    int                errorCnt = 0;
    int                compares = 0;
    int                cyc = 0;
    logic [DATA_W-1:0] d;

    always #25 sys_clk = ~sys_clk;
    always #375 extClk = ~extClk;

    scs_clock_select #(.SETTLE_SLK(2)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .periphRst(periphRst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .slowClockIn(slowClockIn), .factoryTrimLow(fLow), .factoryTrimMid(fMid),
        .factoryTrimHigh(fHigh), .slowClockValid(slowClockValid), .slowRcPower(slowRcPower),
        .slowXtalPower(slowXtalPower), .slowRcEnable(slowRcEnable), .slowXtalEnable(slowXtalEnable),
        .slowXtalPinsToOsc(slowXtalPinsToOsc), .slowXtalBypass(slowXtalBypass),
        .slowSourceXtal(slowSourceXtal), .fastRcEnable(fastRcEnable), .fastRcFreq(fastRcFreq),
        .fastRcTrim(fastRcTrim), .mainClockOn(mainClockOn), .fastRcIrq(fastRcIrq)
    );
    scs_slow_osc_model osc_u (
        .sys_clk(sys_clk), .rcEnable(slowRcEnable), .xtalEnable(slowXtalEnable),
        .bypass(slowXtalBypass), .extClk(extClk), .slowClk(slowClockIn)
    );
    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic summarize();
        $display("Compares %0d errors %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= v;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        v = regRdata;
    endtask
    task automatic waitStable();
        for (int i = 0; i < 100; i++) begin
            rd(PWR_STAT_ADDR, d);
            if (d[STABLE_BIT] === 1'b1) begin
                break;
            end
        end
        chk(mainClockOn, 1'b1, "main clock restarted");
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic testResetState();
        int n;
        chk({slowRcPower, slowXtalPower, slowRcEnable}, 3'h7, "slow osc power");
        chk({slowXtalEnable, slowSourceXtal, slowXtalPinsToOsc}, 3'h0, "crystal idle");
        chk({fastRcEnable, fastRcFreq}, {1'b1, FREQ_4MHZ}, "fast rc reset");
        n = 0;
        while (slowClockValid !== 1'b1 && n < 2100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n >= 1998 && n <= 2002, 1'b1, "slow clock valid delay");
        waitStable();
        rd(8'h1c, d);
        chk(d, 32'h0, "unmapped read");
    endtask
    task automatic testFreq();
        logic [2:0] codes [3] = '{FREQ_8MHZ, FREQ_12MHZ, FREQ_4MHZ};
        foreach (codes[i]) begin
            wr(MAIN_OSC_ADDR, {25'h0, codes[i], 4'h1});
            chk({fastRcFreq, mainClockOn}, {codes[i], 1'b0}, "freq change gates clock");
            waitStable();
        end
        wr(MAIN_OSC_ADDR, 32'h31);
        chk(fastRcFreq, FREQ_4MHZ, "reserved code ignored");
    endtask
    task automatic testEnableIrq();
        wr(PWR_IEN_ADDR, 32'h1);
        @(posedge sys_clk);
        #1;
        chk(fastRcIrq, 1'b1, "irq on stable");
        wr(MAIN_OSC_ADDR, 32'h0);
        chk({fastRcEnable, mainClockOn}, 2'h0, "disable clears stable");
        @(posedge sys_clk);
        #1;
        chk(fastRcIrq, 1'b0, "irq follows stable");
        rd(PWR_STAT_ADDR, d);
        chk(d[STABLE_BIT], 1'b0, "status cleared");
        wr(MAIN_OSC_ADDR, 32'h1);
        waitStable();
        wr(PWR_IEN_ADDR, 32'h0);
        @(posedge sys_clk);
        #1;
        chk(fastRcIrq, 1'b0, "irq masked");
    endtask
    task automatic testTrim();
        chk(fastRcTrim, fLow, "factory low trim");
        wr(OSC_TRIM_ADDR, 32'h0000aad5);
        rd(OSC_TRIM_ADDR, d);
        chk(d, 32'h0000aa00, "in-use trim protected");
        chk(fastRcTrim, fLow, "in-use trim kept");
        wr(MAIN_OSC_ADDR, {25'h0, FREQ_8MHZ, 4'h1});
        @(posedge sys_clk);
        #1;
        chk(fastRcTrim, 7'h2a, "override mid trim");
        @(posedge sys_clk);
        periphRst <= 1'b1;
        @(posedge sys_clk);
        periphRst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(fastRcTrim, fMid, "factory mid after reset");
        rd(OSC_TRIM_ADDR, d);
        chk(d, 32'h0, "trims cleared");
    endtask
    task automatic testSlowSwitch();
        int tPin, tXen, tSrc, tOff;
        tPin = -1;
        tXen = -1;
        tSrc = -1;
        tOff = -1;
        wr(SUP_MODE_ADDR, 32'h1);
        rd(SUP_MODE_ADDR, d);
        chk({d[BYPASS_BIT], slowXtalBypass}, 2'h3, "bypass set");
        wr(SUP_CTRL_ADDR, 32'h1);
        for (int i = 0; i < 400 && tOff < 0; i++) begin
            if (tPin < 0 && slowXtalPinsToOsc === 1'b1) tPin = i;
            if (tXen < 0 && slowXtalEnable === 1'b1) tXen = i;
            if (tSrc < 0 && slowSourceXtal === 1'b1) tSrc = i;
            if (tOff < 0 && slowRcEnable === 1'b0) tOff = i;
            @(posedge sys_clk);
            #1;
        end
        chk(tPin >= 0 && tPin < tXen && tXen < tOff, 1'b1, "switch order");
        chk(tSrc >= tXen && tSrc <= tOff, 1'b1, "source switch");
        rd(SUP_STAT_ADDR, d);
        chk(d[SRC_DONE_BIT], 1'b1, "switch done");
        wr(SUP_CTRL_ADDR, 32'h0);
        repeat (40) @(posedge sys_clk);
        #1;
        chk({slowSourceXtal, slowRcEnable}, 2'h2, "crystal sticky");
        wr(MAIN_OSC_ADDR, 32'h0);
        chk({fastRcEnable, mainClockOn}, 2'h0, "fast rc off on slow clock");
    endtask
    ////////////////////////////////////////////////////////////////
    // Timeout and main sequence
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            errorCnt++;
            $display("Error at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        testResetState();
        testFreq();
        testEnableIrq();
        testTrim();
        testSlowSwitch();
        summarize();
    end
endmodule
